// *** bench/tb_top.sv ***
`timescale 1ns/1ps
`include "overlay_map.svh"

module tb_top;
   import overlay_pkg::*;

   // ************************************************************
   // Signals and counters
   // ************************************************************
   logic        pclk    = 1'b0;
   logic        presetn = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [15:0] paddr   = 16'h0000;
   logic [31:0] pwdata  = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        pix_valid = 1'b0;
   logic        pix_ready;
   logic [7:0]  ovl_alpha = 8'h00;
   logic [23:0] ovl_px    = 24'h000000;
   logic [23:0] main_px   = 24'h000000;
   logic        out_valid;
   logic        out_ready = 1'b1;
   logic [23:0] out_rgb;
   int          errors    = 0;
   int          num_checks = 0;
   logic [23:0] exp_q[$];
   logic [15:0] ctrl_v;
   logic [2:0]  fmt_v;
   logic [23:0] key_v;
   logic [7:0]  alphas[5] = '{8'h00, 8'h01, 8'h0F, 8'h80, 8'hFF};
   logic [2:0]  fmts[4]   = '{3'h0, 3'h4, 3'h5, 3'h6};

   overlay_alpha_blend_key #(.FIFO_DEPTH(16)) i_overlay_alpha_blend_key (
      .pclk                 (pclk),
      .presetn              (presetn),
      .psel                 (psel),
      .penable              (penable),
      .pwrite               (pwrite),
      .paddr                (paddr),
      .pwdata               (pwdata),
      .prdata               (prdata),
      .pready               (pready),
      .pslverr              (pslverr),
      .pix_valid            (pix_valid),
      .pix_ready            (pix_ready),
      .ovl_alpha            (ovl_alpha),
      .overlay_pixel_colour (ovl_px),
      .main_pixel_colour    (main_px),
      .out_valid            (out_valid),
      .out_ready            (out_ready),
      .out_rgb              (out_rgb)
   );

   // Clock, 100 ns period
   always #50 pclk = ~pclk;

   // ************************************************************
   // Helpers
   // ************************************************************
   task automatic final_report();
      if (errors == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("mismatch %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   function automatic logic [15:0] ba(input logic [13:0] idx);
      return {idx, 2'b00};
   endfunction

   // Expected composite pixel
   function automatic logic [23:0] model(input logic [7:0] al, input logic [23:0] ov,
                                         input logic [23:0] mn);
      int          a;
      int          m;
      logic [23:0] r;
      if (!fmt_v[2]) m = 0;
      else if (fmt_v[1:0] == 2'h0) m = al[0] ? 128 : 0;
      else if (fmt_v[1:0] == 2'h1) m = int'(al[3:0]) * 16;
      else m = int'(al);
      if (ctrl_v[10:9] == 2'h1) a = m;
      else if (ctrl_v[10:9] == 2'h2) a = (m * int'(ctrl_v[7:0])) / 256;
      else a = int'(ctrl_v[7:0]);
      if (!ctrl_v[8]) a = 256;
      for (int i = 0; i < 3; i++) begin
         r[i*8+:8] = 8'((int'(ov[i*8+:8]) * a + int'(mn[i*8+:8]) * (256 - a)) / 256);
      end
      if (ctrl_v[12] && ov == key_v) r = mn;
      return r;
   endfunction

   // One APB transfer, completes at the edge where pready is seen high
   task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         errors++;
         final_report();
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [13:0] idx, input logic [31:0] d);
      logic [31:0] rd;
      logic        err;
      apb(1'b1, ba(idx), d, rd, err);
   endtask

   task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp, input logic experr);
      logic [31:0] rd;
      logic        err;
      apb(1'b0, a, 32'h0, rd, err);
      check(rd, exp, "read data");
      check({31'h0, err}, {31'h0, experr}, "slave error");
   endtask

   task automatic cfg(input logic [15:0] c, input logic [2:0] f, input logic [23:0] k);
      ctrl_v = c;
      fmt_v = f;
      key_v = k;
      wr(`OVL_CTRL_IDX, {16'h0, c});
      wr(`OVL_FMT_IDX, {29'h0, f});
      wr(`OVL_KEY_RED_IDX, {24'h0, k[23:16]});
      wr(`OVL_KEY_GREEN_IDX, {24'h0, k[15:8]});
      wr(`OVL_KEY_BLUE_IDX, {24'h0, k[7:0]});
   endtask

   // Offer one pixel, record its expected result on acceptance
   task automatic pix(input logic [7:0] al, input logic [23:0] ov, input logic [23:0] mn);
      int n;
      n = 0;
      @(posedge pclk);
      pix_valid <= 1'b1;
      ovl_alpha <= al;
      ovl_px    <= ov;
      main_px   <= mn;
      do begin
         @(negedge pclk);
         n++;
      end while (pix_ready !== 1'b1 && n < 100);
      if (n >= 100) begin
         errors++;
         final_report();
      end
      exp_q.push_back(model(al, ov, mn));
      @(posedge pclk);
      pix_valid <= 1'b0;
   endtask

   task automatic drain();
      int n;
      for (n = 0; n < 200 && exp_q.size() > 0; n++) @(negedge pclk);
      if (exp_q.size() > 0) begin
         errors++;
         $display("mismatch %0t: results missing", $time);
         exp_q.delete();
      end
   endtask

   // Result monitor, sampled before the taking edge
   always @(negedge pclk) begin
      if (out_valid === 1'b1 && out_ready === 1'b1) begin
         if (exp_q.size() == 0) begin
            errors++;
            $display("mismatch %0t: unexpected result", $time);
         end else begin
            check({8'h0, out_rgb}, {8'h0, exp_q.pop_front()}, "pixel");
         end
      end
   end

   // Watchdog
   initial begin
      #9000000;
      errors++;
      final_report();
   end

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      int n;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(ba(`OVL_CTRL_IDX), 32'h0, 1'b0);
      rd_chk(ba(`OVL_KEY_RED_IDX), 32'h0, 1'b0);
      rd_chk(ba(`OVL_KEY_GREEN_IDX), 32'h0, 1'b0);
      rd_chk(ba(`OVL_KEY_BLUE_IDX), 32'h0, 1'b0);
      wr(`OVL_CTRL_IDX, 32'hFFFF_FFFF);
      rd_chk(ba(`OVL_CTRL_IDX), 32'h0000_17FF, 1'b0);
      wr(`OVL_KEY_RED_IDX, 32'hFFFF_FFFF);
      rd_chk(ba(`OVL_KEY_RED_IDX), 32'h0000_00FF, 1'b0);
      rd_chk(16'h2200, 32'h0, 1'b1);
      // Every mode, formats A1, A4, A8, and none in modes 0 and 3 only, three constants and five alpha values
      for (int md = 0; md < 4; md++) begin
         for (int f = 0; f < 4; f++) begin
            for (int c = 0; c < 3; c++) begin
               cfg({5'h0, 2'(md), 1'b1, (c == 0) ? 8'h40 : (c == 1) ? 8'hFF : 8'h00},
                   fmts[f] | {md[1] ^ md[0], 2'h0}, 24'h0);
               foreach (alphas[i]) pix(alphas[i], 24'hF08040, 24'h103070);
            end
         end
      end
      drain();
      // Blending off shows overlay
      cfg(16'h0040, 3'h6, 24'h0);
      pix(8'h80, 24'h123456, 24'hABCDEF);
      // Key hit, partial misses, and key ignored when disabled
      cfg(16'h1180, 3'h6, 24'h112233);
      pix(8'h80, 24'h112233, 24'hA0B0C0);
      pix(8'h80, 24'h102233, 24'hA0B0C0);
      pix(8'h80, 24'h111233, 24'hA0B0C0);
      pix(8'h80, 24'h112234, 24'hA0B0C0);
      // Transparency on with blending off, key zero-filled in its low bits
      cfg(16'h1000, 3'h6, 24'hF8FC00);
      pix(8'h80, 24'hF8FC00, 24'h0A0B0C);
      pix(8'h80, 24'hF8FC08, 24'h0A0B0C);
      pix(8'h80, 24'hF8F800, 24'h0A0B0C);
      cfg(16'h0140, 3'h6, 24'h112233);
      pix(8'h80, 24'h112233, 24'hA0B0C0);
      drain();
      // Fill the buffer while the consumer stalls, then drain in order
      @(posedge pclk);
      out_ready <= 1'b0;
      n = 0;
      @(posedge pclk);
      pix_valid <= 1'b1;
      for (int k = 0; k < 40; k++) begin
         ovl_alpha <= 8'(k * 13);
         ovl_px    <= {8'(k), 8'(k * 3), 8'(k * 7)};
         main_px   <= 24'h808080;
         @(negedge pclk);
         if (pix_ready !== 1'b1) break;
         exp_q.push_back(model(8'(k * 13), {8'(k), 8'(k * 3), 8'(k * 7)}, 24'h808080));
         n++;
         @(posedge pclk);
      end
      @(posedge pclk);
      pix_valid <= 1'b0;
      check(32'(n >= 16 && n <= 18), 32'h1, "fill count");
      out_ready <= 1'b1;
      drain();
      final_report();
   end

endmodule

// *** design/overlay_alpha_blend_key.sv ***
`timescale 1ns/1ps
`include "overlay_map.svh"

module overlay_alpha_blend_key
   import overlay_pkg::*;
#(
   parameter int FIFO_DEPTH = 16
) (
   input  wire logic        pclk,       // Pixel clock
   input  wire logic        presetn,    // Async reset, low
   input  wire logic        psel,       // APB select
   input  wire logic        penable,    // APB enable
   input  wire logic        pwrite,     // APB direction
   input  wire logic [15:0] paddr,      // APB byte address
   input  wire logic [31:0] pwdata,     // APB write data
   output logic      [31:0] prdata,     // APB read data
   output wire logic        pready,     // APB ready
   output wire logic        pslverr,    // APB error
   input  wire logic        pix_valid,  // Pixel pair offered
   output wire logic        pix_ready,  // Pixel pair taken
   input  wire logic [7:0]  ovl_alpha,  // Overlay alpha field, right aligned
   input  wire logic [23:0] overlay_pixel_colour, // Overlay RGB
   input  wire logic [23:0] main_pixel_colour,    // Main window RGB
   output wire logic        out_valid,  // Result held
   input  wire logic        out_ready,  // Result taken
   output wire logic [23:0] out_rgb     // Composited RGB
);

   localparam int FW = 56;
   localparam int LW = $clog2(FIFO_DEPTH) + 2;

   // Reset images of the packed registers
   localparam logic [15:0] CTRL_RST = `OVL_CTRL_RESET;
   localparam logic [2:0]  FMT_RST  = `OVL_FMT_RESET;

   // ****************************************************************
   // Register state
   // ****************************************************************
   logic [7:0]  const_alpha_reg;
   logic        blend_en_reg;
   blend_mode_t mode_reg;
   logic        trans_en_reg;
   logic [7:0]  key_red_reg;
   logic [7:0]  key_green_reg;
   logic [7:0]  key_blue_reg;
   alpha_fmt_t  fmt_reg;
   logic        alpha_colour_pixel_format_en_reg;
   logic [23:0] out_rgb_reg;
   logic        out_valid_reg;

   // ****************************************************************
   // APB decode
   // ****************************************************************
   function automatic logic hit(input logic [15:0] a, input logic [13:0] idx);
      hit = (a == {idx, 2'b00});
   endfunction

   wire logic sel_ctrl   = hit(paddr, `OVL_CTRL_IDX);
   wire logic sel_red    = hit(paddr, `OVL_KEY_RED_IDX);
   wire logic sel_green  = hit(paddr, `OVL_KEY_GREEN_IDX);
   wire logic sel_blue   = hit(paddr, `OVL_KEY_BLUE_IDX);
   wire logic sel_fmt    = hit(paddr, `OVL_FMT_IDX);
   wire logic sel_status = hit(paddr, `OVL_STATUS_IDX);
   wire logic mapped     = sel_ctrl | sel_red | sel_green | sel_blue | sel_fmt | sel_status;
   wire logic setup      = psel && !penable;
   wire logic wr_acc     = psel && penable && pwrite && mapped;

   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // ****************************************************************
   // FIFO in the pixel path
   // ****************************************************************
   wire logic          head_valid;
   wire logic [FW-1:0] head_data;
   wire logic [LW-1:0] fifo_level;
   wire logic          take = head_valid && (!out_valid_reg || out_ready);

   pixel_fifo #(
      .WIDTH (FW),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (pclk),
      .rst_n     (presetn),
      .in_valid  (pix_valid),
      .in_ready  (pix_ready),
      .in_data   ({ovl_alpha, overlay_pixel_colour, main_pixel_colour}),
      .out_valid (head_valid),
      .out_ready (take),
      .out_data  (head_data),
      .level     (fifo_level)
   );

   wire logic [7:0]  h_alpha = head_data[55:48];
   wire logic [23:0] h_ovl   = head_data[47:24];
   wire logic [23:0] h_main  = head_data[23:0];

   // Status word
   wire logic [31:0] status_word = {22'h000000, !head_valid, !pix_ready,
                                    {(8-LW){1'b0}}, fifo_level};

   // ****************************************************************
   // Register read data, captured in setup phase
   // ****************************************************************
   wire logic [31:0] rd_mux =
      sel_ctrl   ? {19'h00000, trans_en_reg, 1'b0, mode_reg, blend_en_reg,
                    const_alpha_reg} :
      sel_red    ? {24'h000000, key_red_reg} :
      sel_green  ? {24'h000000, key_green_reg} :
      sel_blue   ? {24'h000000, key_blue_reg} :
      sel_fmt    ? {29'h00000000, alpha_colour_pixel_format_en_reg, fmt_reg} :
      sel_status ? status_word : 32'h00000000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) prdata <= 32'h00000000;
      else if (setup && !pwrite) prdata <= rd_mux;
   end

   // ****************************************************************
   // Register writes at the access edge
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         const_alpha_reg <= CTRL_RST[`OVL_CTRL_ALPHA_HI:0];
         blend_en_reg    <= CTRL_RST[`OVL_CTRL_BLEND_BIT];
         mode_reg        <= blend_mode_t'(CTRL_RST[`OVL_CTRL_MODE_HI:`OVL_CTRL_MODE_LO]);
         trans_en_reg    <= CTRL_RST[`OVL_CTRL_TRANS_BIT];
      end else if (wr_acc && sel_ctrl) begin
         const_alpha_reg <= pwdata[`OVL_CTRL_ALPHA_HI:0];
         blend_en_reg    <= pwdata[`OVL_CTRL_BLEND_BIT];
         mode_reg        <= blend_mode_t'(pwdata[`OVL_CTRL_MODE_HI:`OVL_CTRL_MODE_LO]);
         trans_en_reg    <= pwdata[`OVL_CTRL_TRANS_BIT];
      end
   end

   // Key colour and format registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         key_red_reg   <= `OVL_KEY_RESET;
         key_green_reg <= `OVL_KEY_RESET;
         key_blue_reg  <= `OVL_KEY_RESET;
         fmt_reg       <= alpha_fmt_t'(FMT_RST[`OVL_FMT_SEL_HI:0]);
         alpha_colour_pixel_format_en_reg   <= FMT_RST[`OVL_FMT_ALPHA_COLOUR_PIXEL_FORMAT_BIT];
      end else if (wr_acc) begin
         if (sel_red)   key_red_reg   <= pwdata[7:0];
         if (sel_green) key_green_reg <= pwdata[7:0];
         if (sel_blue)  key_blue_reg  <= pwdata[7:0];
         if (sel_fmt)   fmt_reg       <= alpha_fmt_t'(pwdata[`OVL_FMT_SEL_HI:0]);
         if (sel_fmt)   alpha_colour_pixel_format_en_reg   <= pwdata[`OVL_FMT_ALPHA_COLOUR_PIXEL_FORMAT_BIT];
      end
   end

   // ****************************************************************
   // Alpha selection
   // ****************************************************************
   // Map value on a 1/256 grid, zero without alpha pixel format
   wire logic [7:0] map_alpha =
      !alpha_colour_pixel_format_en_reg     ? 8'h00 :
      (fmt_reg == FMT_A1) ? (h_alpha[0] ? `OVL_ALPHA_HALF : 8'h00) :
      (fmt_reg == FMT_A4) ? {h_alpha[3:0], 4'h0} :
      h_alpha;

   wire logic [15:0] prod_alpha = {8'h00, map_alpha} * {8'h00, const_alpha_reg};

   // Mode decode; reserved mode falls back to constant
   wire logic [7:0] sel_alpha =
      (mode_reg == MODE_MAP)       ? map_alpha :
      (mode_reg == MODE_CONST_MAP) ? prod_alpha[15:8] :
      const_alpha_reg;

   // Disabled blending shows the overlay opaque
   wire logic [8:0] eff_alpha = blend_en_reg ? {1'b0, sel_alpha} : `OVL_ALPHA_ONE;

   // Transparency key compare over all three components
   wire logic key_hit = trans_en_reg
                        && (h_ovl[23:16] == key_red_reg)
                        && (h_ovl[15:8]  == key_green_reg)
                        && (h_ovl[7:0]   == key_blue_reg);

   // ****************************************************************
   // Component mixer
   // ****************************************************************
   function automatic logic [7:0] mix(input logic [7:0] p, input logic [7:0] m,
                                      input logic [8:0] a);
      logic [16:0] s;
      s = ({9'h000, p} * {8'h00, a}) + ({9'h000, m} * {8'h00, `OVL_ALPHA_ONE - a});
      mix = s[15:8];
   endfunction

   logic [23:0] blended;

   // One mixer per colour component
   for (genvar c = 0; c < 3; c++) begin : g_mix
      assign blended[c*8 +: 8] = mix(h_ovl[c*8 +: 8], h_main[c*8 +: 8], eff_alpha);
   end

   wire logic [23:0] result = key_hit ? h_main : blended;

   // ****************************************************************
   // Output register stage
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_rgb_reg   <= 24'h000000;
         out_valid_reg <= 1'b0;
      end else if (take) begin
         out_rgb_reg   <= result;
         out_valid_reg <= 1'b1;
      end else if (out_ready) begin
         out_valid_reg <= 1'b0;
      end
   end

   assign out_rgb   = out_rgb_reg;
   assign out_valid = out_valid_reg;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_mode_write;
      wr_acc && sel_ctrl |=> (mode_reg == $past(pwdata[10:9])) && (blend_en_reg == $past(pwdata[8]));
   endproperty
   a_mode_write: assert property (p_mode_write)
      else $error("mode field not taken from write");

   property p_half_mix;
      take && blend_en_reg && mode_reg == MODE_CONST && const_alpha_reg == 8'h80 && !key_hit
      |=> out_rgb[23:16] == $past(8'((9'(h_ovl[23:16]) + 9'(h_main[23:16])) >> 1));
   endproperty
   a_half_mix: assert property (p_half_mix)
      else $error("half alpha mix wrong");

   property p_prod_zero;
      take && blend_en_reg && mode_reg == MODE_CONST_MAP && const_alpha_reg == 8'h00 && !key_hit
      |=> out_rgb == $past(h_main);
   endproperty
   a_prod_zero: assert property (p_prod_zero)
      else $error("product alpha not zero with zero constant");

   property p_const_zero;
      take && blend_en_reg && mode_reg == MODE_CONST && const_alpha_reg == 8'h00 && !key_hit
      |=> out_rgb == $past(h_main);
   endproperty
   a_const_zero: assert property (p_const_zero)
      else $error("zero constant alpha should show main");

   property p_map_a1;
      head_valid && blend_en_reg && mode_reg == MODE_MAP && alpha_colour_pixel_format_en_reg
      && fmt_reg == FMT_A1 |-> eff_alpha == (h_alpha[0] ? 9'h080 : 9'h000);
   endproperty
   a_map_a1: assert property (p_map_a1)
      else $error("one-bit map alpha not 0 or half");

   property p_disabled;
      take && !blend_en_reg && !key_hit |=> out_valid && out_rgb == $past(h_ovl);
   endproperty
   a_disabled: assert property (p_disabled)
      else $error("disabled blend did not pass overlay");

   property p_map_ignores_const;
      head_valid && blend_en_reg && mode_reg == MODE_MAP && alpha_colour_pixel_format_en_reg && fmt_reg == FMT_A8
      |-> eff_alpha == {1'b0, h_alpha};
   endproperty
   a_map_ignores_const: assert property (p_map_ignores_const)
      else $error("constant alpha used in map mode");

   property p_key_off;
      take && !trans_en_reg && !blend_en_reg |=> out_rgb == $past(h_ovl);
   endproperty
   a_key_off: assert property (p_key_off)
      else $error("key acted while transparency off");

   property p_key_hit;
      take && trans_en_reg && h_ovl == {key_red_reg, key_green_reg, key_blue_reg}
      |=> out_rgb == $past(h_main);
   endproperty
   a_key_hit: assert property (p_key_hit)
      else $error("key match did not show main pixel");

   property p_blue_miss;
      take && trans_en_reg && !blend_en_reg && h_ovl[7:0] != key_blue_reg
      |=> out_rgb == $past(h_ovl);
   endproperty
   a_blue_miss: assert property (p_blue_miss)
      else $error("blue mismatch still keyed");

   property p_green_miss;
      take && trans_en_reg && !blend_en_reg && h_ovl[15:8] != key_green_reg
      |=> out_rgb == $past(h_ovl);
   endproperty
   a_green_miss: assert property (p_green_miss)
      else $error("green mismatch still keyed");

   property p_alpha_write;
      wr_acc && sel_ctrl |=> const_alpha_reg == $past(pwdata[7:0]);
   endproperty
   a_alpha_write: assert property (p_alpha_write)
      else $error("constant alpha not taken from write");

   property p_key_red_write;
      wr_acc && sel_red |=> key_red_reg == $past(pwdata[7:0]);
   endproperty
   a_key_red_write: assert property (p_key_red_write)
      else $error("red key not taken from write");

   property p_key_green_write;
      wr_acc && sel_green |=> key_green_reg == $past(pwdata[7:0]);
   endproperty
   a_key_green_write: assert property (p_key_green_write)
      else $error("green key not taken from write");

   property p_key_blue_write;
      wr_acc && sel_blue |=> key_blue_reg == $past(pwdata[7:0]);
   endproperty
   a_key_blue_write: assert property (p_key_blue_write)
      else $error("blue key not taken from write");

   property p_map_a4;
      head_valid && blend_en_reg && mode_reg == MODE_MAP && alpha_colour_pixel_format_en_reg
      && fmt_reg == FMT_A4 |-> eff_alpha == {1'b0, h_alpha[3:0], 4'h0};
   endproperty
   a_map_a4: assert property (p_map_a4)
      else $error("four-bit map alpha not in sixteenths");

   property p_full_const;
      take && blend_en_reg && mode_reg == MODE_CONST && const_alpha_reg == 8'hFF && !key_hit
      |=> out_rgb[7:0] == $past(8'((16'(h_ovl[7:0]) * 16'h00FF + 16'(h_main[7:0])) >> 8));
   endproperty
   a_full_const: assert property (p_full_const)
      else $error("near full constant alpha mix wrong");

endmodule

// *** design/overlay_map.svh ***
`ifndef OVERLAY_MAP_SVH
`define OVERLAY_MAP_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define OVL_CTRL_IDX      14'h0836
`define OVL_KEY_RED_IDX   14'h0838
`define OVL_KEY_GREEN_IDX 14'h083A
`define OVL_KEY_BLUE_IDX  14'h083C
`define OVL_FMT_IDX       14'h0840
`define OVL_STATUS_IDX    14'h0842

// ****************************************************************
// Control register fields
// ****************************************************************
`define OVL_CTRL_TRANS_BIT 12
`define OVL_CTRL_MODE_HI   10
`define OVL_CTRL_MODE_LO   9
`define OVL_CTRL_BLEND_BIT 8
`define OVL_CTRL_ALPHA_HI  7

// ****************************************************************
// Format register fields
// ****************************************************************
`define OVL_FMT_SEL_HI     1
`define OVL_FMT_ALPHA_COLOUR_PIXEL_FORMAT_BIT   2

// ****************************************************************
// Reset values
// ****************************************************************
`define OVL_CTRL_RESET     16'h0000
`define OVL_KEY_RESET      8'h00
`define OVL_FMT_RESET      3'h0

// ****************************************************************
// Alpha scale: full opacity on a 1/256 grid
// ****************************************************************
`define OVL_ALPHA_ONE      9'h100
`define OVL_ALPHA_HALF     8'h80

`endif

// *** design/overlay_pkg.sv ***
package overlay_pkg;

   // Blending mode selected by the control register
   typedef enum logic [1:0] {
      MODE_CONST     = 2'h0,
      MODE_MAP       = 2'h1,
      MODE_CONST_MAP = 2'h2,
      MODE_RESERVED  = 2'h3
   } blend_mode_t;

   // Alpha width of the overlay pixel format
   typedef enum logic [1:0] {
      FMT_A1 = 2'h0,
      FMT_A4 = 2'h1,
      FMT_A8 = 2'h2,
      FMT_RSV = 2'h3
   } alpha_fmt_t;

endpackage

// *** design/pixel_fifo.sv ***
`timescale 1ns/1ps

// ****************************************************************
// Pixel FIFO with registered head
// ****************************************************************
module pixel_fifo #(
   parameter int WIDTH = 56,
   parameter int DEPTH = 16,
   parameter int AW    = $clog2(DEPTH)
) (
   input  wire logic             clk,        // Clock
   input  wire logic             rst_n,      // Async reset, low
   input  wire logic             in_valid,   // Write request
   output wire logic             in_ready,   // Space in memory
   input  wire logic [WIDTH-1:0] in_data,    // Write data
   output wire logic             out_valid,  // Head holds data
   input  wire logic             out_ready,  // Head taken
   output wire logic [WIDTH-1:0] out_data,   // Registered head
   output wire logic [AW+1:0]    level       // Words held
);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      count_reg;
   logic [WIDTH-1:0] head_reg;
   logic             head_valid_reg;

   // Handshake decode
   wire logic push = in_valid && in_ready;
   wire logic load = (count_reg != '0) && (!head_valid_reg || out_ready);

   assign in_ready  = (count_reg != (AW+1)'(DEPTH));
   assign out_valid = head_valid_reg;
   assign out_data  = head_reg;
   assign level     = {1'b0, count_reg} + {{(AW+1){1'b0}}, head_valid_reg};

   // Storage array
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   // Pointers and count
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
         if (load) rd_ptr_reg <= rd_ptr_reg + 1'b1;
         count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(load);
      end
   end

   // Head register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         head_reg       <= '0;
         head_valid_reg <= 1'b0;
      end else if (load) begin
         head_reg       <= mem[rd_ptr_reg];
         head_valid_reg <= 1'b1;
      end else if (out_ready) begin
         head_valid_reg <= 1'b0;
      end
   end

endmodule
